// file: verilog/sbc_pkg.sv
// Overview of operation
// - accepted irq saves state, enters management mode
// - then acknowledge bus cycle, then run handler
// - irq held at reset release tri-states outputs
// - stop-clock request enters low-power grant state
// - grant entry issues grant acknowledge bus cycle
// - grant gates core clocks, bus/irq clocks run
// - grant keeps snooping and servicing interrupts
// - request release restarts clocks, resumes execution
// - stop-clock asynchronous, bus clock untouched
// - socket-presence output always held low
// - test data shifts in/out, timed by test clock
package sbc_pkg;
   // synchroniser depth
   localparam int SYNC_STAGES = 3;
   // cycles spent saving state before mode switch
   localparam int SAVE_CYCLES = 4;
   // width of the save counter
   localparam int SAVE_W      = 3;
   // width of the response-status group
   localparam int RESP_W      = 3;
   // response status that completes a transaction (active low code)
   localparam logic [2:0] RESP_DONE_N = 3'h6;
   // response status while no agent is completing anything
   localparam logic [2:0] RESP_IDLE_N = 3'h7;
   // acknowledge transaction kinds
   localparam logic [1:0] ACK_NONE  = 2'h0;
   localparam logic [1:0] ACK_MGMT  = 2'h1;
   localparam logic [1:0] ACK_GRANT = 2'h2;
   // sequencer states, one-hot
   typedef enum logic [5:0] {
      SBC_RUN      = 6'h01,   // normal execution
      SBC_SAVE     = 6'h02,   // saving execution state
      SBC_MGMT_ACK = 6'h04,   // management acknowledge cycle on bus
      SBC_HANDLER  = 6'h08,   // running management handler
      SBC_GNT_ACK  = 6'h10,   // grant acknowledge cycle on bus
      SBC_GRANT    = 6'h20    // low-power grant state
   } sbc_state_t;
endpackage : sbc_pkg

// file: verilog/sbc_sync_if.sv
`timescale 1ns/1ps
// carries raw sideband levels in and synchronised levels out
interface sbc_sync_if;
   logic mgmt_raw_n;  // raw management irq, active low
   logic stop_raw_n;  // raw stop-clock request, active low
   logic mgmt_n;      // synchronised management irq
   logic stop_n;      // synchronised stop-clock request
   modport sync (input mgmt_raw_n, input stop_raw_n, output mgmt_n, output stop_n);
   modport user (output mgmt_raw_n, output stop_raw_n, input mgmt_n, input stop_n);
endinterface : sbc_sync_if

// file: verilog/sbc_sync.sv
`timescale 1ns/1ps
// multi-stage synchroniser for both sideband request inputs
module sbc_sync
   import sbc_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // sideband levels
   sbc_sync_if.sync sif
);
   logic [STAGES-1:0] mgmt_q;  // irq shift chain
   logic [STAGES-1:0] stop_q;  // stop-clock shift chain

   // shift chains, idle high; only the last stage is read outside
   always_ff @(posedge clk) begin
      if (reset) begin
         mgmt_q <= '1;
         stop_q <= '1;
      end else begin
         mgmt_q <= {mgmt_q[STAGES-2:0], sif.mgmt_raw_n};
         stop_q <= {stop_q[STAGES-2:0], sif.stop_raw_n};
      end
   end

   assign sif.mgmt_n = mgmt_q[STAGES-1];
   assign sif.stop_n = stop_q[STAGES-1];
endmodule : sbc_sync

// file: verilog/sbc_ctrl.sv
`timescale 1ns/1ps
// sideband control: management interrupt and stop-clock sequencing
module sbc_ctrl
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // sideband requests from system logic
   input  wire logic              sys_mgmt_irq_n,
   input  wire logic              stop_clock_req_n,
   // bus response status from the response agent
   input  wire logic [RESP_W-1:0] response_status_n,
   // core-side handshakes
   input  wire logic              irq_pending,
   input  wire logic              snoop_req,
   input  wire logic              rsm_done,
   // bus acknowledge request
   output logic                   ack_req,
   output logic [1:0]             ack_kind,
   // core status
   output logic                   save_state,
   output logic                   sys_mgmt_mode,
   output logic                   handler_start,
   output logic                   core_clk_en,
   output logic                   bus_clk_en,
   output logic                   irq_ctl_clk_en,
   output logic                   snoop_en,
   output logic                   irq_service,
   output logic                   outputs_tristate,
   output logic                   socket_present_n,
   // test port
   input  wire logic              test_clk,
   input  wire logic              test_data_in,
   output logic                   test_data_out
);
   sbc_sync_if   sif ();           // synchroniser link
   sbc_state_t   state;            // sequencer state
   sbc_state_t   next_state;       // next sequencer state
   logic [SAVE_W-1:0] save_cnt;    // save-phase counter
   logic         reset_q;          // reset delayed a cycle
   logic         resp_done;        // bus cycle completed
   logic         test_q;           // test shift stage

   assign sif.mgmt_raw_n = sys_mgmt_irq_n;
   assign sif.stop_raw_n = stop_clock_req_n;

   // synchroniser for both asynchronous inputs
   sbc_sync #(.STAGES(SYNC_STAGES)) u_sync (
      .clk   (clk),
      .reset (reset),
      .sif   (sif)
   );

   // completion seen from the response agent's status
   assign resp_done = (response_status_n == RESP_DONE_N);

   // next-state logic
   always_comb begin
      next_state = state;
      case (state)
         SBC_RUN: begin
            if (!sif.mgmt_n) next_state = SBC_SAVE;
            else if (!sif.stop_n) next_state = SBC_GNT_ACK;
         end
         SBC_SAVE: begin
            if (save_cnt == SAVE_W'(SAVE_CYCLES - 1)) next_state = SBC_MGMT_ACK;
         end
         SBC_MGMT_ACK: begin
            if (resp_done) next_state = SBC_HANDLER;
         end
         SBC_HANDLER: begin
            if (rsm_done) next_state = SBC_RUN;
         end
         SBC_GNT_ACK: begin
            if (resp_done) next_state = SBC_GRANT;
         end
         SBC_GRANT: begin
            if (sif.stop_n) next_state = SBC_RUN;
         end
         default: next_state = SBC_RUN;
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (reset) state <= SBC_RUN;
      else state <= next_state;
   end

   // save-phase counter
   always_ff @(posedge clk) begin
      if (reset || state != SBC_SAVE) save_cnt <= '0;
      else save_cnt <= save_cnt + SAVE_W'(1);
   end

   // registered acknowledge and mode outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         ack_req       <= 1'b0;
         ack_kind      <= ACK_NONE;
         save_state    <= 1'b0;
         sys_mgmt_mode <= 1'b0;
         handler_start <= 1'b0;
      end else begin
         ack_req       <= (next_state == SBC_MGMT_ACK) || (next_state == SBC_GNT_ACK);
         ack_kind      <= (next_state == SBC_MGMT_ACK) ? ACK_MGMT :
                          (next_state == SBC_GNT_ACK) ? ACK_GRANT : ACK_NONE;
         save_state    <= (next_state == SBC_SAVE);
         sys_mgmt_mode <= (next_state == SBC_MGMT_ACK) || (next_state == SBC_HANDLER);
         handler_start <= (state == SBC_MGMT_ACK) && (next_state == SBC_HANDLER);
      end
   end

   // clock gating and grant-state service enables
   always_ff @(posedge clk) begin
      if (reset) begin
         core_clk_en    <= 1'b1;
         bus_clk_en     <= 1'b1;
         irq_ctl_clk_en <= 1'b1;
         snoop_en       <= 1'b1;
         irq_service    <= 1'b0;
      end else begin
         core_clk_en    <= (next_state != SBC_GRANT);
         bus_clk_en     <= 1'b1;
         irq_ctl_clk_en <= 1'b1;
         snoop_en       <= 1'b1;
         irq_service    <= irq_pending || snoop_req ? irq_pending : 1'b0;
      end
   end

   // strap capture at reset release: irq low tri-states outputs
   always_ff @(posedge clk) begin
      reset_q <= reset;
      if (reset) outputs_tristate <= 1'b0;
      else if (reset_q && !sys_mgmt_irq_n) outputs_tristate <= 1'b1;
   end

   // socket presence is pulled low permanently
   always_ff @(posedge clk) begin
      socket_present_n <= 1'b0;
   end

   // test data path on the test clock
   always_ff @(posedge test_clk) begin
      test_q <= test_data_in;
   end
   always_ff @(negedge test_clk) begin
      test_data_out <= test_q;
   end

   // assertions
   property p_ack_after_save;
      @(posedge clk) disable iff (reset)
      (state == SBC_SAVE && next_state == SBC_MGMT_ACK) |=> ack_req && ack_kind == ACK_MGMT;
   endproperty
   a_ack_after_save: assert property (p_ack_after_save) else $error("no mgmt ack after save");
   property p_save_len;
      @(posedge clk) disable iff (reset)
      $rose(state == SBC_SAVE) |-> (state == SBC_SAVE) [*4] ##1 (state == SBC_MGMT_ACK);
   endproperty
   a_save_len: assert property (p_save_len) else $error("save phase length wrong");
   property p_mgmt_enter;
      @(posedge clk) disable iff (reset)
      (state == SBC_RUN && !sif.mgmt_n) |=> state == SBC_SAVE;
   endproperty
   a_mgmt_enter: assert property (p_mgmt_enter) else $error("mgmt irq not taken");
   property p_grant_ack;
      @(posedge clk) disable iff (reset)
      (state == SBC_RUN && sif.mgmt_n && !sif.stop_n) |=> ack_req && ack_kind == ACK_GRANT;
   endproperty
   a_grant_ack: assert property (p_grant_ack) else $error("no grant ack");
   property p_gate;
      @(posedge clk) disable iff (reset)
      (state == SBC_GRANT) |-> !core_clk_en && bus_clk_en && irq_ctl_clk_en && snoop_en;
   endproperty
   a_gate: assert property (p_gate) else $error("grant clock gating wrong");
   property p_resume;
      @(posedge clk) disable iff (reset)
      (state == SBC_GRANT && sif.stop_n) |=> core_clk_en && state == SBC_RUN;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume after release");
   property p_socket;
      @(posedge clk) disable iff (reset) !socket_present_n;
   endproperty
   a_socket: assert property (p_socket) else $error("socket presence high");
   property p_sync_lat;
      @(posedge clk) disable iff (reset)
      $fell(sys_mgmt_irq_n) ##1 !sys_mgmt_irq_n [*2] |=> !sif.mgmt_n;
   endproperty
   a_sync_lat: assert property (p_sync_lat) else $error("sync latency wrong");
   property p_tristate;
      @(posedge clk) (reset_q && !reset && !sys_mgmt_irq_n) |=> outputs_tristate;
   endproperty
   a_tristate: assert property (p_tristate) else $error("no tristate at release");
   c_mgmt: cover property (@(posedge clk) state == SBC_HANDLER);
   c_grant: cover property (@(posedge clk) state == SBC_GRANT);
   c_resume: cover property (@(posedge clk) state == SBC_GRANT ##1 state == SBC_RUN);
   c_tri: cover property (@(posedge clk) outputs_tristate);
endmodule : sbc_ctrl

// file: verification/sbc_partner.sv
`timescale 1ns/1ps
// response agent model: completes each acknowledge cycle after a chosen wait
module sbc_partner
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            reset,
   // acknowledge request and wait length
   input  wire logic            ack_req,
   input  wire logic [1:0]      wait_len,
   // status back to the device
   output logic [RESP_W-1:0]    response_status_n
);
   int cnt;   // cycles waited on this request
   // idle code differs from completion, completion stands one cycle only
   always_ff @(posedge clk) begin
      if (reset || !ack_req || response_status_n == RESP_DONE_N) begin
         cnt               <= 0;
         response_status_n <= RESP_IDLE_N;
      end else if (cnt >= wait_len) begin
         response_status_n <= RESP_DONE_N;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : sbc_partner

// file: verification/tb_sbc_ctrl.sv
`timescale 1ns/1ps
// bench for the sideband sequencer
module tb_sbc_ctrl;
   import sbc_pkg::*;
   logic clk = 0, reset = 1, irq_n = 1, stop_n = 1, irq_pending = 0, snoop_req = 0, rsm_done = 0, test_data_in = 0;
   logic [1:0] wait_len = 0, tcnt = 0;   // partner wait, test clock divider
   logic [RESP_W-1:0] resp_n;               // status from partner
   logic ack_req, save_state, sys_mgmt_mode, handler_start, core_clk_en, bus_clk_en, irq_ctl_clk_en;
   logic snoop_en, irq_service, outputs_tristate, socket_present_n, test_data_out, last, bit_q;
   logic [1:0] ack_kind;
   logic td_exp[$];   // expected test-port bits, oldest first
   int n_fail = 0, n_checks = 0, cyc = 0, i, k, n, saves;
   integer seed = 32'h4389;
   sbc_ctrl dut_u (.clk(clk), .reset(reset), .sys_mgmt_irq_n(irq_n), .stop_clock_req_n(stop_n),
      .response_status_n(resp_n), .irq_pending(irq_pending), .snoop_req(snoop_req), .rsm_done(rsm_done),
      .ack_req(ack_req), .ack_kind(ack_kind), .save_state(save_state), .sys_mgmt_mode(sys_mgmt_mode),
      .handler_start(handler_start), .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en),
      .irq_ctl_clk_en(irq_ctl_clk_en), .snoop_en(snoop_en), .irq_service(irq_service),
      .outputs_tristate(outputs_tristate), .socket_present_n(socket_present_n), .test_clk(tcnt[1]),
      .test_data_in(test_data_in), .test_data_out(test_data_out));
   sbc_partner part_u (.clk(clk), .reset(reset), .ack_req(ack_req), .wait_len(wait_len), .response_status_n(resp_n));
   // 50 ns clock
   always #25 clk = ~clk;
   // test clock at a quarter rate, plus hang guard
   always @(posedge clk) begin
      tcnt <= tcnt + 2'h1;
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         print_verdict();
      end
   end
   // compare seen against expected
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t mismatch seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   // verdict and end of run
   task automatic print_verdict();
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (3) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      // management sequence with a prompt and a slow response agent
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         check(outputs_tristate, 0);
         check(socket_present_n, 0);
         wait_len <= 2'(i * 3);
         irq_n    <= 0;
         n = 0;
         saves = 0;
         do begin
            @(posedge clk);
            n++;
            saves += (save_state === 1'b1);
         end while (ack_req !== 1'b1 && n < 40);
         check(saves, SAVE_CYCLES);
         check(n, SYNC_STAGES + SAVE_CYCLES + 2);
         check(ack_kind, ACK_MGMT);
         check(sys_mgmt_mode, 1);
         irq_n <= 1;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (handler_start !== 1'b1 && n < 20);
         check(handler_start, 1);
         check(sys_mgmt_mode, 1);
         rsm_done <= 1;
         @(posedge clk);
         rsm_done <= 0;
         repeat (3) @(posedge clk);
         check(sys_mgmt_mode, 0);
      end
      // stop-clock request into grant and back
      stop_n <= 0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack_req !== 1'b1 && n < 40);
      check(ack_kind, ACK_GRANT);
      check(core_clk_en, 1);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (core_clk_en !== 1'b0 && n < 20);
      check(core_clk_en, 0);
      for (k = 0; k < 8; k++) begin
         @(posedge clk);
         if (k > 0) check(irq_service, last);
         check({snoop_en, bus_clk_en, irq_ctl_clk_en, core_clk_en}, 4'he);
         last = irq_pending;
         irq_pending <= 1'($random(seed));
         snoop_req   <= 1'($random(seed));
      end
      stop_n <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (core_clk_en !== 1'b1 && n < 20);
      check(n, SYNC_STAGES + 2);
      // serial test data through the test port
      for (k = 0; k < 10; k++) begin
         do @(posedge clk); while (tcnt !== 2'h0);
         if (k > 0) check(test_data_out, td_exp.pop_front());
         bit_q = 1'($random(seed));
         td_exp.push_back(bit_q);   // model: bits leave in the order they enter
         test_data_in <= bit_q;
      end
      // request held low across reset release, then a clean reset
      reset <= 1;
      irq_n <= 0;
      repeat (3) @(posedge clk);
      reset <= 0;
      repeat (3) @(posedge clk);
      check(outputs_tristate, 1);
      reset <= 1;
      irq_n <= 1;
      repeat (3) @(posedge clk);
      reset <= 0;
      repeat (2) @(posedge clk);
      check(outputs_tristate, 0);
      check(ack_req, 0);
      print_verdict();
   end
endmodule : tb_sbc_ctrl
